// >>> rtl/cfrr_pkg.sv
/*
  constants, types and register map of the acceptance-filter register group.
  assumes a 32-bit AXI4-Lite master and 8-bit registers in the low byte lane.
*/
package cfrr_pkg;

  // ==========================================================================
  // bus
  // ==========================================================================
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ==========================================================================
  // register map, byte address = index * 4
  // ==========================================================================
  localparam int unsigned NREG = 31;
  localparam int unsigned IDX_ENABLE = 0;
  localparam int unsigned IDX_LINK0 = 1;
  localparam int unsigned IDX_LINK1 = 2;
  localparam int unsigned IDX_LINK2 = 3;
  localparam int unsigned IDX_LINK7 = 8;
  localparam int unsigned IDX_ID0 = 9;
  localparam int unsigned ID_FULL = 20;
  localparam int unsigned ID_PER_FILTER = 4;
  localparam int unsigned ID_STD_LOW_POS = 2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 32'h0000_0080;

  // ==========================================================================
  // reset values and field layouts
  // ==========================================================================
  localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
  localparam logic [REG_W-1:0] RST_LINK12 = 8'h11;
  localparam logic [REG_W-1:0] RST_ID = 8'h00;
  localparam logic [REG_W-1:0] MASK_ALL = 8'hFF;
  localparam logic [REG_W-1:0] MASK_STD_LOW = 8'hEB;

  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic hit_reg;
    logic hit_ctrl;
    logic [4:0] idx;
  } cfrr_dec_t;

  typedef struct packed {
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [REG_W-1:0] wdata;
    logic wen;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [REG_W-1:0] rdata;
    logic [1:0] mode;
    logic [NREG-1:0][REG_W-1:0] regs;
  } cfrr_state_t;

endpackage : cfrr_pkg

// >>> rtl/cfrr_top.sv
/*
  acceptance-filter register group: enable, eight filter-to-buffer links and
  the identifier registers of filters 10 to 15, behind an AXI4-Lite slave.
  assumes nrst_i is the power-on/brown-out reset and warm_rst_i a one-cycle
  or longer synchronous pulse for pin, watchdog, instruction or stack reset.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01 - Enable and links 0 and 3 to 7 clear to zero on every reset kind, not on wake-up.
// R02 - Links 1 and 2 load 0x11 on every reset kind, not on wake-up.
// R03 - Identifier registers are undefined after power-on and kept over warm resets; power-on loads them with 0x00.
// R04 - Standard-identifier low registers have bits 4 and 2 unimplemented, read as zero.
// R05 - Every group register reads zero until the controller runs in mode 1 or mode 2.
// R06 - In mode 1 or 2 writes to implemented bits are stored and read back.
module cfrr_top (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic warm_rst_i,
  input wire logic [cfrr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [cfrr_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [cfrr_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [cfrr_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [1:0] mode_o,
  output logic [cfrr_pkg::REG_W-1:0] filter_enable_bank0_o
);

  // ==========================================================================
  // functions
  // ==========================================================================
  function automatic cfrr_pkg::cfrr_dec_t decode(input logic [cfrr_pkg::ADDR_W-1:0] a);
    cfrr_pkg::cfrr_dec_t r;
    logic [cfrr_pkg::ADDR_W-1:0] wi;
    r = '0;
    wi = a >> 2;
    if (a == cfrr_pkg::ADDR_CTRL) begin
      r.hit_ctrl = 1'b1;
    end else if (a[1:0] == cfrr_pkg::WORD_ALIGN && wi < cfrr_pkg::NREG) begin
      r.hit_reg = 1'b1;
      r.idx = wi[4:0];
    end
    return r;
  endfunction : decode

  function automatic logic is_std_low(input int unsigned i);
    int unsigned k;
    k = i - cfrr_pkg::IDX_ID0;
    return (i >= cfrr_pkg::IDX_ID0) && (k < cfrr_pkg::ID_FULL)
      && ((k % cfrr_pkg::ID_PER_FILTER) == cfrr_pkg::ID_STD_LOW_POS);
  endfunction : is_std_low

  function automatic logic [cfrr_pkg::REG_W-1:0] impl_mask(input int unsigned i);
    return is_std_low(i) ? cfrr_pkg::MASK_STD_LOW : cfrr_pkg::MASK_ALL;
  endfunction : impl_mask

  function automatic logic [cfrr_pkg::REG_W-1:0] warm_val(input int unsigned i);
    if (i == cfrr_pkg::IDX_LINK1 || i == cfrr_pkg::IDX_LINK2) begin
      return cfrr_pkg::RST_LINK12; // R02
    end
    return cfrr_pkg::RST_ZERO; // R01
  endfunction : warm_val

  function automatic logic mode_active(input logic [1:0] m);
    return (m == cfrr_pkg::MODE_1) || (m == cfrr_pkg::MODE_2);
  endfunction : mode_active

  // ==========================================================================
  // state
  // ==========================================================================
  cfrr_pkg::cfrr_state_t state_q;
  cfrr_pkg::cfrr_state_t state_d;
  cfrr_pkg::cfrr_dec_t wdec;
  cfrr_pkg::cfrr_dec_t rdec;
  logic mode_on;

  assign mode_on = mode_active(state_q.mode);

  always_comb begin
    state_d = state_q;
    wdec = decode(state_q.aw_addr);
    rdec = decode(s_axi_araddr_i);
    if (state_q.bvalid && s_axi_bready_i) begin
      state_d.bvalid = 1'b0;
    end
    if (state_q.rvalid && s_axi_rready_i) begin
      state_d.rvalid = 1'b0;
    end
    // capture address and data in either order
    if (s_axi_awvalid_i && !state_q.aw_have) begin
      state_d.aw_have = 1'b1;
      state_d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !state_q.w_have) begin
      state_d.w_have = 1'b1;
      state_d.wdata = s_axi_wdata_i[cfrr_pkg::REG_W-1:0];
      state_d.wen = s_axi_wstrb_i[0];
    end
    // write commit once both halves are held
    if (state_q.aw_have && state_q.w_have && !state_q.bvalid) begin
      state_d.aw_have = 1'b0;
      state_d.w_have = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = (wdec.hit_reg || wdec.hit_ctrl) ? cfrr_pkg::RESP_OKAY
        : cfrr_pkg::RESP_SLVERR;
      if (state_q.wen && !warm_rst_i) begin
        if (wdec.hit_ctrl) begin
          state_d.mode = state_q.wdata[1:0];
        end else if (wdec.hit_reg && mode_on) begin
          state_d.regs[wdec.idx] = state_q.wdata & impl_mask(int'(wdec.idx)); // R06 R04
        end
      end
    end
    // read
    if (s_axi_arvalid_i && !state_q.rvalid) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = (rdec.hit_reg || rdec.hit_ctrl) ? cfrr_pkg::RESP_OKAY
        : cfrr_pkg::RESP_SLVERR;
      if (rdec.hit_ctrl) begin
        state_d.rdata = {{(cfrr_pkg::REG_W-2){1'b0}}, state_q.mode};
      end else if (rdec.hit_reg && mode_on) begin
        state_d.rdata = state_q.regs[rdec.idx]; // R06
      end else begin
        state_d.rdata = cfrr_pkg::RST_ZERO; // R05
      end
    end
    // warm reset: identifier registers keep their value
    if (warm_rst_i) begin
      state_d.mode = cfrr_pkg::MODE_0;
      for (int unsigned i = 0; i < cfrr_pkg::IDX_ID0; i++) begin
        state_d.regs[i] = warm_val(i); // R01 R02 R03
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= '0;
      for (int unsigned i = 0; i < cfrr_pkg::NREG; i++) begin
        state_q.regs[i] <= (i < cfrr_pkg::IDX_ID0) ? warm_val(i) : cfrr_pkg::RST_ID; // R01 R02 R03
      end
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready_o = !state_q.aw_have;
  assign s_axi_wready_o = !state_q.w_have;
  assign s_axi_bvalid_o = state_q.bvalid;
  assign s_axi_bresp_o = state_q.bresp;
  assign s_axi_arready_o = !state_q.rvalid;
  assign s_axi_rvalid_o = state_q.rvalid;
  assign s_axi_rresp_o = state_q.rresp;
  assign s_axi_rdata_o = cfrr_pkg::DATA_W'(state_q.rdata);
  assign mode_o = state_q.mode;
  assign filter_enable_bank0_o = state_q.regs[cfrr_pkg::IDX_ENABLE];

  // ==========================================================================
  // assertions
  // ==========================================================================
  logic std_low_clean;
  always_comb begin
    std_low_clean = 1'b1;
    for (int unsigned i = 0; i < cfrr_pkg::NREG; i++) begin
      if ((state_q.regs[i] & ~impl_mask(i)) != cfrr_pkg::RST_ZERO) begin
        std_low_clean = 1'b0;
      end
    end
  end

  AST_R01_WARM_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R01
    warm_rst_i |=> (state_q.regs[cfrr_pkg::IDX_ENABLE] == cfrr_pkg::RST_ZERO)
      && (state_q.regs[cfrr_pkg::IDX_LINK0] == cfrr_pkg::RST_ZERO)
      && (state_q.regs[cfrr_pkg::IDX_LINK7:cfrr_pkg::IDX_LINK2 + 1] == '0))
    else $error("enable or links not cleared by warm reset");

  AST_R02_WARM_LINK12: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R02
    warm_rst_i |=> (state_q.regs[cfrr_pkg::IDX_LINK1] == cfrr_pkg::RST_LINK12)
      && (state_q.regs[cfrr_pkg::IDX_LINK2] == cfrr_pkg::RST_LINK12))
    else $error("links 1 and 2 not loaded by warm reset");

  AST_R03_ID_KEPT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R03
    warm_rst_i |=> state_q.regs[cfrr_pkg::NREG-1:cfrr_pkg::IDX_ID0]
      == $past(state_q.regs[cfrr_pkg::NREG-1:cfrr_pkg::IDX_ID0]))
    else $error("identifier registers changed by warm reset");

  AST_R04_UNIMPL_ZERO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R04
    std_low_clean)
    else $error("unimplemented identifier bit is set");

  AST_R05_READ_ZERO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    (s_axi_arvalid_i && s_axi_arready_o && !mode_on && decode(s_axi_araddr_i).hit_reg)
      |=> s_axi_rvalid_o && (s_axi_rdata_o == '0))
    else $error("group register read nonzero outside mode 1 or 2");

  AST_R06_STORE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (state_q.aw_have && state_q.w_have && !state_q.bvalid && state_q.wen && mode_on
      && !warm_rst_i && wdec.hit_reg)
      |=> state_q.regs[$past(wdec.idx)] == ($past(state_q.wdata) & impl_mask(int'($past(wdec.idx)))))
    else $error("write in active mode not stored");

  AST_R06_WRITE_RESP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_bvalid_o)
      |=> ##1 s_axi_bvalid_o)
    else $error("write response late");

  AST_R05_READ_RESP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    (s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o [*1] ##0 !s_axi_arready_o)
    else $error("read response late");

  // ==========================================================================
  // assertion helpers
  // ==========================================================================
  logic wr_commit;
  logic rd_take;

  // write lands in the cycle both halves are held and no response is pending
  assign wr_commit = state_q.aw_have && state_q.w_have && !state_q.bvalid;
  assign rd_take = s_axi_arvalid_i && s_axi_arready_o;

  // ==========================================================================
  // bus handshake checks
  // ==========================================================================
  AST_R06_BVALID_HOLD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before bready");

  AST_R06_RVALID_HOLD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (s_axi_rvalid_o && !s_axi_rready_i)
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read response dropped before rready");

  AST_R06_BVALID_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (s_axi_bvalid_o && s_axi_bready_i) |=> !s_axi_bvalid_o)
    else $error("write response not cleared after bready");

  AST_R06_RVALID_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (s_axi_rvalid_o && s_axi_rready_i) |=> !s_axi_rvalid_o)
    else $error("read response not cleared after rready");

  AST_R06_BVALID_CAUSE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    $rose(s_axi_bvalid_o) |-> $past(wr_commit))
    else $error("write response without a write");

  AST_R06_RVALID_CAUSE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    $rose(s_axi_rvalid_o) |-> $past(rd_take))
    else $error("read response without a read");

  AST_R06_COMMIT_RESP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    wr_commit |=> s_axi_bvalid_o)
    else $error("write committed without a response");

  AST_R06_READY_BACK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    wr_commit |=> s_axi_awready_o && s_axi_wready_o)
    else $error("address or data channel stays blocked after a write");

  AST_R06_ADDR_KEEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (state_q.aw_have && !wr_commit) |=> state_q.aw_have && $stable(state_q.aw_addr))
    else $error("held write address lost");

  AST_R06_DATA_KEEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (state_q.w_have && !wr_commit) |=> state_q.w_have && $stable(state_q.wdata))
    else $error("held write data lost");

  AST_R06_WR_OKAY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (wr_commit && (wdec.hit_reg || wdec.hit_ctrl))
      |=> s_axi_bresp_o == cfrr_pkg::RESP_OKAY)
    else $error("mapped write not answered okay");

  AST_R06_WR_SLVERR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (wr_commit && !wdec.hit_reg && !wdec.hit_ctrl)
      |=> s_axi_bresp_o == cfrr_pkg::RESP_SLVERR)
    else $error("unmapped write not answered with error");

  AST_R05_RD_SLVERR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    (rd_take && !rdec.hit_reg && !rdec.hit_ctrl)
      |=> (s_axi_rresp_o == cfrr_pkg::RESP_SLVERR) && (s_axi_rdata_o == '0))
    else $error("unmapped read not answered with error and zero");

  AST_R05_RDATA_UPPER: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    s_axi_rvalid_o |-> s_axi_rdata_o[cfrr_pkg::DATA_W-1:cfrr_pkg::REG_W] == '0)
    else $error("read data upper lanes not zero");

  // ==========================================================================
  // register content checks
  // ==========================================================================
  AST_R06_RD_ACTIVE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (rd_take && mode_on && rdec.hit_reg)
      |=> s_axi_rdata_o == cfrr_pkg::DATA_W'($past(state_q.regs[rdec.idx])))
    else $error("active read does not return stored value");

  AST_R04_STD_LOW_READ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R04
    (rd_take && rdec.hit_reg && is_std_low(int'(rdec.idx)))
      |=> (s_axi_rdata_o[cfrr_pkg::REG_W-1:0] & ~cfrr_pkg::MASK_STD_LOW) == cfrr_pkg::RST_ZERO)
    else $error("unimplemented identifier bit read as one");

  AST_R05_RD_CTRL: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    (rd_take && rdec.hit_ctrl) |=> s_axi_rdata_o[1:0] == $past(state_q.mode))
    else $error("control read does not return mode");

  AST_R05_CTRL_WRITE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    (wr_commit && state_q.wen && !warm_rst_i && wdec.hit_ctrl)
      |=> mode_o == $past(state_q.wdata[1:0]))
    else $error("control write not stored");

  AST_R05_WARM_MODE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    warm_rst_i |=> mode_o == cfrr_pkg::MODE_0)
    else $error("mode not cleared by warm reset");

  AST_R05_MODE_QUIET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    (!(wr_commit && wdec.hit_ctrl) && !warm_rst_i) |=> $stable(mode_o))
    else $error("mode changed without a control write");

  AST_R05_INACTIVE_WRITE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R05
    (wr_commit && wdec.hit_reg && !mode_on && !warm_rst_i)
      |=> state_q.regs == $past(state_q.regs))
    else $error("group register written outside mode 1 or 2");

  AST_R06_STROBE_OFF: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (wr_commit && !state_q.wen && !warm_rst_i)
      |=> (state_q.regs == $past(state_q.regs)) && $stable(mode_o))
    else $error("write with low-lane strobe off changed state");

  AST_R06_REGS_QUIET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R06
    (!wr_commit && !warm_rst_i) |=> state_q.regs == $past(state_q.regs))
    else $error("register changed without write or reset");

  AST_R01_WARM_PIN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R01
    warm_rst_i |=> filter_enable_bank0_o == cfrr_pkg::RST_ZERO)
    else $error("enable output not cleared by warm reset");

endmodule : cfrr_top

`default_nettype wire

// >>> bench/tb_top.sv
/*
  self-checking bench for cfrr_top: reset values, mode gating, masked bits and
  warm reset of the filter register group, driven over AXI4-Lite.
  assumes the register map, control register and reset pins of cfrr_pkg and cfrr_top.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic warm = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, mode, resp;
  logic [7:0] en;
  logic [3:0] wstrb = 4'h1;
  logic [31:0] got;
  int bad_count = 0;
  int cmp_count = 0;

  cfrr_top cfrr_top_inst (.ref_clk_i(clk), .nrst_i(nrst), .warm_rst_i(warm),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .mode_o(mode),
    .filter_enable_bank0_o(en));

  // ==========================================================================
  // clock, reporting and bus tasks
  // ==========================================================================
  always #25 clk = ~clk;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk

  task automatic hang(input string what);
    bad_count++;
    $display("mismatch at %0t: %s timed out", $time, what);
    end_sim();
  endtask : hang

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_hit, w_hit, b_hit;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      aw_hit = awvalid && awready === 1'b1;
      w_hit = wvalid && wready === 1'b1;
      b_hit = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) begin
        bready <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_hit, r_hit;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ar_hit = arvalid && arready === 1'b1;
      r_hit = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) begin
        rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask : rd

  task automatic wrc(input logic [31:0] a, input logic [31:0] d);
    wr(a, d, resp);
    chk({30'h0, resp}, {30'h0, cfrr_pkg::RESP_OKAY}, "bresp");
  endtask : wrc

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    rd(a, got, resp);
    chk(got, e, $sformatf("read %h", a));
    chk({30'h0, resp}, {30'h0, cfrr_pkg::RESP_OKAY}, "rresp");
  endtask : rdc

  task automatic links_default();
    for (int i = 0; i < 8; i++) begin
      rdc(32'(4 + 4 * i), (i == 1 || i == 2) ? 8'h11 : 8'h00);
    end
    rdc(8'h00, 8'h00);
  endtask : links_default

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_idle();
    rdc(8'h00, 8'h00);
    rdc(8'h08, 8'h00);
    chk({30'h0, mode}, 32'h0000_0000, "mode after reset");
    chk({24'h0, en}, 32'h0000_0000, "enable pins");
    $display("test idle done");
  endtask : t_idle

  task automatic t_defaults();
    wrc(cfrr_pkg::ADDR_CTRL, 8'h01);
    links_default();
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_rw();
    wrc(8'h00, 8'hA5);
    rdc(8'h00, 8'hA5);
    chk({24'h0, en}, 32'h0000_00A5, "enable pins");
    wrc(8'h24, 8'h5A);
    rdc(8'h24, 8'h5A);
    wstrb <= 4'h0;
    wrc(8'h24, 8'h11);
    wstrb <= 4'h1;
    rdc(8'h24, 8'h5A);
    wrc(8'h78, 8'h3C);
    rdc(8'h78, 8'h3C);
    for (int k = 0; k < 5; k++) begin
      wrc(32'(8'h2C + 16 * k), 8'hFF);
      rdc(32'(8'h2C + 16 * k), 8'hEB);
    end
    $display("test readback done");
  endtask : t_rw

  task automatic t_warm();
    for (int i = 0; i < 8; i++) wrc(32'(4 + 4 * i), 8'hFF);
    @(posedge clk);
    warm <= 1'b1;
    @(posedge clk);
    warm <= 1'b0;
    @(negedge clk);
    chk({30'h0, mode}, 32'h0000_0000, "mode after warm reset");
    rdc(8'h24, 8'h00);
    wrc(cfrr_pkg::ADDR_CTRL, 8'h02);
    links_default();
    chk({24'h0, en}, 32'h0000_0000, "enable pins");
    rdc(8'h24, 8'h5A);
    rdc(8'h2C, 8'hEB);
    rdc(8'h78, 8'h3C);
    $display("test warm reset done");
  endtask : t_warm

  task automatic t_odd();
    wrc(cfrr_pkg::ADDR_CTRL, 8'h03);
    rdc(8'h24, 8'h00);
    wr(8'h84, 8'h77, resp);
    chk({30'h0, resp}, {30'h0, cfrr_pkg::RESP_SLVERR}, "unmapped bresp");
    rd(8'h84, got, resp);
    chk({30'h0, resp}, {30'h0, cfrr_pkg::RESP_SLVERR}, "unmapped rresp");
    chk(got, 32'h0000_0000, "unmapped data");
    $display("test mode 3 and unmapped done");
  endtask : t_odd

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_idle();
    t_defaults();
    t_rw();
    t_warm();
    t_odd();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
